// ===== bench/pin_board.sv
// Board model for the port pins
`timescale 1ns/1ns
`default_nettype none
module pin_board (
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] drv,
  input wire logic [31:0] drv_en,
  output logic [31:0] lvl
);
  // Released pins go to the pull-up level, never a stale value
  always_comb begin
    for (int i = 0; i < 32; i++) lvl[i] = pin_oe[i] ? pin_o[i] : (drv_en[i] ? drv[i] : 1'b1);
  end
endmodule : pin_board
`default_nettype wire

// ===== bench/testbench.sv
// Random self-checking bench for the pin crossbar
`timescale 1ns/1ns
`default_nettype none
module testbench
  import xbar_pkg::*;
;
  logic clk = 0, sys_rst = 1, we = 0, cyc = 0, stb = 0, ack;
  logic [31:0] adr = 0, wd = 0, rd, pin_o, pin_oe, lvl, drv = 0, drv_en = 0;
  logic [31:0] lat, ex, r, dv, dm;
  logic [NSIG-1:0] pout = 0, pin_in, epi;
  logic [8:0] en;
  logic [7:0] im;
  logic [4:0] bp;
  logic mb;
  int seed = 32'h61305757, num_errors = 0, cmp_count = 0, pin_of [NSIG];
  always #5 clk = ~clk;
  priority_pin_crossbar dut (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .periph_out(pout), .periph_in(pin_in), .pin_i(lvl), .pin_o(pin_o),
    .pin_oe(pin_oe));
  pin_board board (.pin_o(pin_o), .pin_oe(pin_oe), .drv(drv), .drv_en(drv_en), .lvl(lvl));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Classic cycle; waits for ack, bounded
  task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    adr <= {26'h0, a};
    we <= w;
    wd <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    r = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Expected pinout: next free, non-skipped pin in priority order
  function automatic void alloc(input logic [8:0] e, input logic [31:0] skip);
    int p;
    p = 0;
    for (int s = 0; s < NSIG; s++) begin
      pin_of[s] = -1;
      if (e[SIG_GRP[s]]) begin
        while (p < NPIN && skip[p]) p++;
        if (p < NPIN) pin_of[s] = p;
        p++;
      end
    end
  endfunction : alloc
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("oe after reset", 32'h0, pin_oe);
    chk("periph_in after reset", {16'h0, SIG_IDLE}, {16'h0, pin_in});
    wb(OFF_LATCH_RD, 1'b0, 32'h0);
    chk("latch reset", {4{PORT_RST}}, r);
    wb(6'h24, 1'b1, 32'h5A);
    wb(6'h24, 1'b0, 32'h0);
    chk("unmapped read", 32'h0, r);
    for (int it = 0; it < 40; it++) begin
      en = (it == 0) ? 9'h1FF : (it == 1) ? 9'h001 : 9'($random(seed));
      im = (it == 0) ? 8'hFF : (it == 1) ? 8'h00 : 8'($random(seed));
      mb = (it > 1) ? 1'($random(seed)) : (it == 1);
      lat = $random(seed);
      dv = $random(seed);
      bp = 5'($random(seed));
      pout <= 16'($random(seed));
      wb(OFF_CONFIG, 1'b1, {30'h0, mb, 1'b0});
      wb(OFF_PERIPH_EN, 1'b1, {23'h0, en});
      wb(OFF_P1_INMODE, 1'b1, {24'h0, im});
      for (int q = 0; q < 4; q++) wb(6'(4 * q), 1'b1, {24'h0, lat[8*q +: 8]});
      wb(OFF_BITSET, 1'b1, {23'h0, ~lat[bp], 3'h0, bp});
      lat[bp] = ~lat[bp];
      repeat (4) @(posedge clk);
      chk("oe before global enable", 32'h0, pin_oe);
      wb(OFF_CONFIG, 1'b1, {30'h0, mb, 1'b1});
      alloc(en, (mb ? MEMBUS_PINS : 32'h0) | {16'h0, ~im, 8'h0});
      ex = lat;
      dm = 32'h0;
      epi = SIG_IDLE;
      for (int s = 0; s < NSIG; s++) begin
        if (pin_of[s] >= 0 && SIG_IS_OUT[s]) ex[pin_of[s]] = pout[s];
        if (pin_of[s] >= 0 && !SIG_IS_OUT[s]) begin
          dm[pin_of[s]] = 1'b1;
          ex[pin_of[s]] = dv[pin_of[s]];
          epi[s] = dv[pin_of[s]];
        end
      end
      drv <= dv;
      drv_en <= dm;
      repeat (8) @(posedge clk);
      chk("pin level", ex, lvl);
      chk("input pin oe", 32'h0, pin_oe & dm);
      chk("periph_in", {16'h0, epi | SIG_IS_OUT}, {16'h0, pin_in | SIG_IS_OUT});
      for (int q = 0; q < 4; q++) begin
        wb(6'(4 * q), 1'b0, 32'h0);
        chk("port read", {24'h0, ex[8*q +: 8] & ((q == 1) ? im : 8'hFF)}, r);
      end
      wb(OFF_LATCH_RD, 1'b0, 32'h0);
      chk("latch read", lat, r);
      drv_en <= 32'h0;
      $display("test %0d done, enables %h", it, en);
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire

// ===== hw/priority_pin_crossbar.sv
// Priority pin crossbar with port data registers on a Wishbone slave
// Summary of operation
// RULE1 - Pins handed out from port 0 pin 0 upward, highest priority first
// RULE2 - Default pattern: no memory reservation, port 1 digital, next free pins
// RULE3 - First serial port, when enabled, always sits on port 0 pins 0 and 1
// RULE4 - A disabled peripheral gets no pins at all
// RULE5 - A serial peripheral gets all its signals together
// RULE6 - Pinout depends only on the set of enabled peripherals; the code also uses the memory reservation and port 1 analog mode
// RULE7 - Unallocated pins are GPIO through port data registers, byte or bit
// RULE8 - Allocated pin outputs come from the peripheral; data writes do not matter
// RULE9 - Normal reads return the sampled pin level
// RULE10 - Read-modify-write reads return the data latch
// RULE11 - All output drivers stay off until the global enable is set
// RULE12 - Pins carrying peripheral inputs have their drivers forced off
// RULE13 - Software configures the crossbar first, then enables, then leaves it
// RULE14 - Analog port 1 pins are skipped by the allocator
// RULE15 - Unrouted peripheral inputs are held at their idle level
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module priority_pin_crossbar
  import xbar_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [NSIG-1:0] periph_out,
  output logic [NSIG-1:0] periph_in,
  input wire logic [NPIN-1:0] pin_i,
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe
);
  // ==========================================================================
  // Pin synchroniser: three stages, change accepted when stage 2 and 3 agree
  logic [NPIN-1:0] sync1_q, sync2_q, sync3_q, pin_lvl_q, pin_lvl_d;
  always_ff @(posedge clk) begin
    sync1_q <= pin_i;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
    pin_lvl_q <= pin_lvl_d;
  end
  // Per-bit acceptance; a glitch seen by stage 2 alone never reaches the level
  for (genvar g = 0; g < NPIN; g++) begin : g_pin_filter
    wire agree = sync2_q[g] == sync3_q[g];
    assign pin_lvl_d[g] = agree ? sync3_q[g] : pin_lvl_q[g];
  end

  // ==========================================================================
  // Registers
  logic [7:0] port_q [4];
  logic [10:0] periph_en_q;
  logic global_en_q, membus_rsv_q;
  logic [7:0] p1_inmode_q;
  logic ack_q;
  logic [31:0] rdata_q;
  wire [3:0] reg_idx = wb_adr_i[5:2];
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = req && wb_we_i && wb_sel_i[0];
  wire [5:0] off = {reg_idx, 2'b00};
  wire [4:0] bit_pin = wb_dat_i[4:0];

  // ==========================================================================
  // Allocator: walk signals in priority order, each enabled signal takes the next eligible pin
  logic [NPIN-1:0] eligible;
  logic [NSIG-1:0] sig_en;
  logic [4:0] sig_pin [NSIG];
  logic [NSIG-1:0] sig_placed;
  assign eligible = ~({NPIN{membus_rsv_q}} & MEMBUS_PINS)
    & ~{16'h0000, ~p1_inmode_q, 8'h00}; // [RULE2] [RULE14]
  always_comb begin
    for (int s = 0; s < NSIG; s++) begin
      sig_en[s] = periph_en_q[SIG_GRP[s]]; // [RULE4] [RULE5]
    end
  end
  always_comb begin
    logic [5:0] next;
    next = 6'd0;
    for (int s = 0; s < NSIG; s++) begin
      sig_pin[s] = 5'd0;
      sig_placed[s] = 1'b0;
      if (sig_en[s]) begin // [RULE1] [RULE6]
        while (next < 6'(NPIN) && !eligible[next[4:0]]) next = next + 6'd1;
        if (next < 6'(NPIN)) begin
          sig_pin[s] = next[4:0];
          sig_placed[s] = 1'b1;
          next = next + 6'd1;
        end
      end
    end
  end

  // Per-pin ownership, output value and drive
  logic [NPIN-1:0] own, own_out, own_val;
  logic [NSIG-1:0] in_route;
  always_comb begin
    own = '0;
    own_out = '0;
    own_val = '0;
    for (int s = 0; s < NSIG; s++) begin
      if (sig_placed[s]) begin
        own[sig_pin[s]] = 1'b1;
        own_out[sig_pin[s]] = SIG_IS_OUT[s];
        own_val[sig_pin[s]] = periph_out[s]; // [RULE8]
      end
    end
  end
  always_comb begin
    for (int s = 0; s < NSIG; s++) begin
      in_route[s] = sig_placed[s] ? pin_lvl_q[sig_pin[s]] : SIG_IDLE[s]; // [RULE15]
    end
  end
  wire [NPIN-1:0] latch_flat = {port_q[3], port_q[2], port_q[1], port_q[0]};
  // Open-drain GPIO: a 0 in the latch pulls the pin low, a 1 releases it
  logic [NPIN-1:0] oe_d, val_d;
  for (genvar g = 0; g < NPIN; g++) begin : g_pin_drive
    wire gpio_oe = ~latch_flat[g];
    wire periph_oe = own_out[g]; // [RULE12]
    wire sel_oe = own[g] ? periph_oe : gpio_oe;
    assign oe_d[g] = global_en_q & sel_oe; // [RULE11]
    assign val_d[g] = own[g] ? own_val[g] : latch_flat[g]; // [RULE7] [RULE8]
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_oe <= '0;
      pin_o <= '0;
      periph_in <= SIG_IDLE;
    end else begin
      pin_oe <= oe_d;
      pin_o <= val_d;
      periph_in <= in_route;
    end
  end

  // ==========================================================================
  // Bus read mux; analog port 1 pins read as 0
  wire [NPIN-1:0] pin_rd = pin_lvl_q & ~{16'h0000, ~p1_inmode_q, 8'h00};
  logic [31:0] rd_d;
  always_comb begin
    case (off)
      OFF_PORT0: rd_d = {24'h000000, pin_rd[7:0]}; // [RULE9]
      OFF_PORT1: rd_d = {24'h000000, pin_rd[15:8]};
      OFF_PORT2: rd_d = {24'h000000, pin_rd[23:16]};
      OFF_PORT3: rd_d = {24'h000000, pin_rd[31:24]};
      OFF_LATCH_RD: rd_d = latch_flat; // [RULE10]
      OFF_PERIPH_EN: rd_d = {21'h0, periph_en_q};
      OFF_CONFIG: rd_d = {30'h0, membus_rsv_q, global_en_q};
      OFF_P1_INMODE: rd_d = {24'h000000, p1_inmode_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
      for (int p = 0; p < 4; p++) port_q[p] <= PORT_RST;
      periph_en_q <= PERIPH_EN_RST;
      global_en_q <= 1'b0;
      membus_rsv_q <= 1'b0;
      p1_inmode_q <= P1_INMODE_RST;
    end else begin
      ack_q <= req;
      rdata_q <= req ? rd_d : 32'h00000000;
      if (wr) begin
        case (off)
          OFF_PORT0: port_q[0] <= wb_dat_i[7:0]; // [RULE7]
          OFF_PORT1: port_q[1] <= wb_dat_i[7:0];
          OFF_PORT2: port_q[2] <= wb_dat_i[7:0];
          OFF_PORT3: port_q[3] <= wb_dat_i[7:0];
          OFF_BITSET: port_q[bit_pin[4:3]][bit_pin[2:0]] <= wb_dat_i[BIT_VAL]; // [RULE7]
          OFF_PERIPH_EN: if (wb_sel_i[1]) periph_en_q <= wb_dat_i[10:0];
          OFF_CONFIG: begin
            global_en_q <= wb_dat_i[CFG_GLOBAL_EN];
            membus_rsv_q <= wb_dat_i[CFG_MEMBUS_RSV];
          end
          OFF_P1_INMODE: p1_inmode_q <= wb_dat_i[7:0];
          default: ;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ==========================================================================
  // Assertions
  property p_drv_off;
    @(posedge clk) disable iff (sys_rst)
      !$past(global_en_q) |-> pin_oe == '0;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver on while disabled"); // [RULE11]

  property p_first_oe;
    @(posedge clk) disable iff (sys_rst)
      $past(global_en_q && sig_en[0]) |-> pin_oe[0] && !pin_oe[1];
  endproperty
  a_first_oe: assert property (p_first_oe) else $error("serial port drive wrong"); // [RULE3]

  property p_ack_one;
    @(posedge clk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than a cycle");

  property p_ack_resp;
    @(posedge clk) disable iff (sys_rst)
      $past(req) |-> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered");

  property p_dat_zero;
    @(posedge clk) disable iff (sys_rst)
      !wb_ack_o |-> wb_dat_o == '0;
  endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");

  property p_noalloc;
    @(posedge clk) disable iff (sys_rst)
      !sig_en[0] |-> !sig_placed[0] && !sig_placed[1];
  endproperty
  a_noalloc: assert property (p_noalloc) else $error("disabled port got pins"); // [RULE4]

  property p_pair;
    @(posedge clk) disable iff (sys_rst)
      sig_placed[2] == sig_placed[3] && sig_placed[0] == sig_placed[1];
  endproperty
  a_pair: assert property (p_pair) else $error("serial pair split"); // [RULE5]

  property p_skip;
    @(posedge clk) disable iff (sys_rst)
      !p1_inmode_q[0] |-> !own[8];
  endproperty
  a_skip: assert property (p_skip) else $error("analog pin allocated"); // [RULE14]

  property p_membus;
    @(posedge clk) disable iff (sys_rst)
      membus_rsv_q |-> (own & MEMBUS_PINS) == '0;
  endproperty
  a_membus: assert property (p_membus) else $error("reserved pin allocated"); // [RULE2]

  property p_idle_in;
    @(posedge clk) disable iff (sys_rst)
      !$past(sig_placed[1]) && !$past(sys_rst) |-> periph_in[1] == SIG_IDLE[1];
  endproperty
  a_idle_in: assert property (p_idle_in) else $error("unrouted input not idle"); // [RULE15]

  property p_route_in;
    @(posedge clk) disable iff (sys_rst)
      $past(sig_placed[1]) |-> periph_in[1] == $past(pin_lvl_q[1]);
  endproperty
  a_route_in: assert property (p_route_in) else $error("routed input wrong"); // [RULE3]

  property p_in_off;
    @(posedge clk) disable iff (sys_rst)
      $past(own[1] && !own_out[1]) |-> !pin_oe[1];
  endproperty
  a_in_off: assert property (p_in_off) else $error("input pin driven"); // [RULE12]

  property p_first;
    @(posedge clk) disable iff (sys_rst)
      sig_en[0] |-> sig_pin[0] == 5'd0 && sig_pin[1] == 5'd1;
  endproperty
  a_first: assert property (p_first) else $error("first serial misplaced"); // [RULE3]

  property p_periph_val;
    @(posedge clk) disable iff (sys_rst)
      $past(sig_en[0]) |-> pin_o[0] == $past(periph_out[0]);
  endproperty
  a_periph_val: assert property (p_periph_val) else $error("peripheral value lost"); // [RULE8]

  property p_gpio_oe;
    @(posedge clk) disable iff (sys_rst)
      $past(global_en_q && !own[31]) |-> pin_oe[31] == !$past(latch_flat[31]);
  endproperty
  a_gpio_oe: assert property (p_gpio_oe) else $error("gpio drive wrong"); // [RULE7]

  property p_latch_rd;
    @(posedge clk) disable iff (sys_rst)
      $past(req && !wb_we_i && off == OFF_LATCH_RD) |-> wb_dat_o == $past(latch_flat);
  endproperty
  a_latch_rd: assert property (p_latch_rd) else $error("latch read wrong"); // [RULE10]

  property p_pin_rd;
    @(posedge clk) disable iff (sys_rst)
      $past(req && !wb_we_i && off == OFF_PORT0) |-> wb_dat_o == {24'h0, $past(pin_lvl_q[7:0])};
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin read wrong"); // [RULE9]

  property p_bitset;
    @(posedge clk) disable iff (sys_rst)
      $past(wr && off == OFF_BITSET) |-> latch_flat[$past(bit_pin)] == $past(wb_dat_i[BIT_VAL]);
  endproperty
  a_bitset: assert property (p_bitset) else $error("bit write lost"); // [RULE7]

  property p_cfg_write;
    @(posedge clk) disable iff (sys_rst)
      $past(wr && off == OFF_CONFIG) |-> global_en_q == $past(wb_dat_i[CFG_GLOBAL_EN]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("enable write lost"); // [RULE11]

  property p_in_reset;
    @(posedge clk) disable iff (sys_rst)
      $past(sys_rst) |-> periph_in == SIG_IDLE && pin_oe == '0;
  endproperty
  a_in_reset: assert property (p_in_reset) else $error("reset state wrong"); // [RULE15]

  c_enable: cover property (@(posedge clk) $rose(global_en_q));
  c_uart: cover property (@(posedge clk) sig_placed[0] && global_en_q);
  c_write: cover property (@(posedge clk) wr && off == OFF_BITSET);
  c_membus: cover property (@(posedge clk) membus_rsv_q && global_en_q);
  c_analog: cover property (@(posedge clk) global_en_q && p1_inmode_q != 8'hFF);
endmodule : priority_pin_crossbar
`default_nettype wire

// ===== hw/xbar_pkg.sv
// Package: register map, field positions and peripheral slots of the pin crossbar
package xbar_pkg;
  // ==========================================================================
  // Register byte offsets on the Wishbone slave
  localparam logic [5:0] OFF_PORT0 = 6'h00;
  localparam logic [5:0] OFF_PORT1 = 6'h04;
  localparam logic [5:0] OFF_PORT2 = 6'h08;
  localparam logic [5:0] OFF_PORT3 = 6'h0C;
  localparam logic [5:0] OFF_LATCH_RD = 6'h10;
  localparam logic [5:0] OFF_PERIPH_EN = 6'h14;
  localparam logic [5:0] OFF_CONFIG = 6'h18;
  localparam logic [5:0] OFF_P1_INMODE = 6'h1C;
  localparam logic [5:0] OFF_BITSET = 6'h20;
  // ==========================================================================
  // Field positions in the config register
  localparam int CFG_GLOBAL_EN = 0;
  localparam int CFG_MEMBUS_RSV = 1;
  // Bit access register: [4:0] pin index, [8] value
  localparam int BIT_VAL = 8;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] PORT_RST = 8'hFF;
  localparam logic [7:0] P1_INMODE_RST = 8'hFF;
  localparam logic [10:0] PERIPH_EN_RST = 11'h000;
  // ==========================================================================
  // Peripheral groups in priority order, highest first
  localparam int NGRP = 11;
  localparam int NSIG = 16;
  localparam int NPIN = 32;
  // Signal table: group, output(1)/input(0)
  localparam logic [3:0] SIG_GRP [NSIG] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2,
    4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
  localparam logic [NSIG-1:0] SIG_IS_OUT = 16'h2FF5;
  // Pins reserved for the memory bus when the low ports are claimed
  localparam logic [NPIN-1:0] MEMBUS_PINS = 32'h0000_00E0;
  // Inactive level of each input when unrouted
  localparam logic [NSIG-1:0] SIG_IDLE = 16'hFFFF;
endpackage : xbar_pkg
